// >>> hdl/dec_inc_jump_execute.sv
// Execute stage for decimal adjust, decrement, skip, jump and increment
`timescale 1ns/10ps
// Function
// - Decimal adjust after sub converts the accumulator to packed decimal in one cycle, no flags.
// - Decrement reg subtracts one from register 0..63, routes by destination, updates zero.
// - Decrement skip zero subtracts one, routes by destination, and changes no flags.
// - A zero result of decrement skip zero discards the fetched next instruction as a nop.
// - Jump absolute loads the 10-bit immediate to bits 9..0 and page bit 2 to bit 10.
// - Jump absolute always takes two cycles because the fetched instruction is flushed.
// - Increment reg adds one to register 0..63, routes by destination, updates zero.
module dec_inc_jump_execute
   import exec_pkg::*;
#(
   parameter int DATA_W = 8
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Decoded instruction and operands
   input wire exec_pkg::instr_t instr,
   input wire logic [exec_pkg::DataW-1:0] regData,
   input wire logic [exec_pkg::DataW-1:0] pageHighBuffer,
   input wire logic lowBorrow,
   input wire logic highBorrow,
   // Results
   output exec_pkg::reg_wr_t regWrite,
   output exec_pkg::flag_upd_t flagUpdate,
   output logic [exec_pkg::DataW-1:0] accumulator,
   output logic [exec_pkg::PcW-1:0] programCounter,
   output logic pcLoad,
   output logic flushCycle
);
   // The nibble logic serves only the core byte width
   if (DATA_W != DataW)
   begin
      $error("DATA_W must equal the core data width");
   end

   state_t state_r, state_nxt;
   logic [DataW-1:0] acc_r, acc_nxt;
   logic [PcW-1:0] pc_r, pc_nxt;
   logic pcLoad_r, pcLoad_nxt;
   reg_wr_t regWrite_r, regWrite_nxt;
   flag_upd_t flag_r, flag_nxt;
   logic [DataW-1:0] adjusted;
   logic [DataW-1:0] result;
   logic execNow;

   decimal_adjust_sub adjuster (
      .valueIn(acc_r),
      .lowBorrow(lowBorrow),
      .highBorrow(highBorrow),
      .valueOut(adjusted)
   );

   // A flush cycle executes the fetched instruction as a nop
   assign execNow = instr.valid && (state_r == ST_RUN);

   // Next-state and result computation
   always_comb
   begin
      state_nxt = ST_RUN;
      acc_nxt = acc_r;
      pc_nxt = pc_r;
      pcLoad_nxt = 1'b0;
      regWrite_nxt = '0;
      flag_nxt = '0;
      result = DataZero;
      if (execNow)
      begin
         case (instr.op)
            OP_DECIMAL_ADJUST_AFTER_SUB:
            begin
               acc_nxt = adjusted;
            end
            OP_DECREMENT_REG, OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_REG:
            begin
               if (instr.op == OP_INCREMENT_REG)
               begin
                  result = regData + DataOne;
               end
               else
               begin
                  result = regData - DataOne;
               end
               if (instr.destReg)
               begin
                  regWrite_nxt = '{en: 1'b1, addr: instr.regAddr, data: result};
               end
               else
               begin
                  acc_nxt = result;
               end
               if (instr.op != OP_DECREMENT_SKIP_ZERO)
               begin
                  flag_nxt = '{zeroEn: 1'b1, zero: (result == DataZero)};
               end
               else if (result == DataZero)
               begin
                  state_nxt = ST_FLUSH;
               end
            end
            OP_JUMP_ABSOLUTE:
            begin
               pc_nxt = {pageHighBuffer[PageBit], instr.imm};
               pcLoad_nxt = 1'b1;
               state_nxt = ST_FLUSH;
            end
            default:
            begin
               state_nxt = ST_RUN;
            end
         endcase
      end
   end

   // Registers only
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         state_r <= ST_RUN;
         acc_r <= AccReset;
         pc_r <= PcReset;
         pcLoad_r <= 1'b0;
         regWrite_r <= '0;
         flag_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         acc_r <= acc_nxt;
         pc_r <= pc_nxt;
         pcLoad_r <= pcLoad_nxt;
         regWrite_r <= regWrite_nxt;
         flag_r <= flag_nxt;
      end
   end

   assign accumulator = acc_r;
   assign programCounter = pc_r;
   assign pcLoad = pcLoad_r;
   assign regWrite = regWrite_r;
   assign flagUpdate = flag_r;
   assign flushCycle = (state_r == ST_FLUSH);

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   a_adjust_no_flags: assert property (
      execNow && instr.op == OP_DECIMAL_ADJUST_AFTER_SUB |=> !flagUpdate.zeroEn
         && accumulator == $past(adjusted))
      else $error("decimal adjust result or flags wrong");
   a_dec_zero_flag: assert property (
      execNow && instr.op == OP_DECREMENT_REG |=> flagUpdate.zeroEn
         && flagUpdate.zero == ($past(regData) == DataOne))
      else $error("decrement zero flag wrong");
   a_dec_route_reg: assert property (
      execNow && instr.op == OP_DECREMENT_REG && instr.destReg |=> regWrite.en
         && regWrite.data == $past(regData) - DataOne)
      else $error("decrement register write wrong");
   a_skip_no_flags: assert property (
      execNow && instr.op == OP_DECREMENT_SKIP_ZERO |=> !flagUpdate.zeroEn)
      else $error("skip variant touched flags");
   a_skip_flush: assert property (
      execNow && instr.op == OP_DECREMENT_SKIP_ZERO |=>
         flushCycle == ($past(regData) == DataOne))
      else $error("skip flush wrong");
   a_jump_target: assert property (
      execNow && instr.op == OP_JUMP_ABSOLUTE |=> pcLoad
         && programCounter == {$past(pageHighBuffer[PageBit]), $past(instr.imm)})
      else $error("jump target wrong");
   a_jump_two_cycles: assert property (
      execNow && instr.op == OP_JUMP_ABSOLUTE |=> flushCycle ##1 !flushCycle)
      else $error("jump not two cycles");
   a_inc_route_acc: assert property (
      execNow && instr.op == OP_INCREMENT_REG && !instr.destReg |=> !regWrite.en
         && accumulator == $past(regData) + DataOne && flagUpdate.zeroEn)
      else $error("increment to accumulator wrong");
   a_flush_is_nop: assert property (
      flushCycle |=> !regWrite.en && !pcLoad && !flagUpdate.zeroEn)
      else $error("flushed instruction executed");

   // Routing of the remaining destination choices
   a_dec_route_acc: assert property (
      execNow && instr.op == OP_DECREMENT_REG && !instr.destReg |=> !regWrite.en
         && accumulator == $past(regData) - DataOne)
      else $error("decrement to accumulator wrong");
   a_skip_route_acc: assert property (
      execNow && instr.op == OP_DECREMENT_SKIP_ZERO && !instr.destReg |=> !regWrite.en
         && accumulator == $past(regData) - DataOne)
      else $error("skip to accumulator wrong");
   a_skip_route_reg: assert property (
      execNow && instr.op == OP_DECREMENT_SKIP_ZERO && instr.destReg |=> regWrite.en
         && regWrite.addr == $past(instr.regAddr)
         && regWrite.data == $past(regData) - DataOne)
      else $error("skip register write wrong");
   a_inc_route_reg: assert property (
      execNow && instr.op == OP_INCREMENT_REG && instr.destReg |=> regWrite.en
         && regWrite.addr == $past(instr.regAddr)
         && regWrite.data == $past(regData) + DataOne
         && flagUpdate.zeroEn && flagUpdate.zero == (&$past(regData)))
      else $error("increment register write wrong");

   // Cycle counts and untouched state; a flush may be followed at once by a new branch
   a_flush_one_cycle: assert property (
      flushCycle |=> !flushCycle)
      else $error("flush lasted more than one cycle");
   a_jump_keeps_state: assert property (
      execNow && instr.op == OP_JUMP_ABSOLUTE |=> !regWrite.en && !flagUpdate.zeroEn
         && accumulator == $past(accumulator))
      else $error("jump changed data or flags");
   a_adjust_one_cycle: assert property (
      execNow && instr.op == OP_DECIMAL_ADJUST_AFTER_SUB |=> !flushCycle && !pcLoad
         && !regWrite.en)
      else $error("decimal adjust not single cycle");

   c_skip_taken: cover property (execNow && instr.op == OP_DECREMENT_SKIP_ZERO ##1 flushCycle);
   c_jump: cover property (execNow && instr.op == OP_JUMP_ABSOLUTE ##2 !flushCycle);
   c_inc_reg: cover property (execNow && instr.op == OP_INCREMENT_REG && instr.destReg);
   c_adjust: cover property (execNow && instr.op == OP_DECIMAL_ADJUST_AFTER_SUB);
   c_dec_acc: cover property (execNow && instr.op == OP_DECREMENT_REG && !instr.destReg);
endmodule

// >>> hdl/exec_pkg.sv
// Package of opcodes, widths, field layouts and carrier structs for the execute block
package exec_pkg;
   localparam int DataW = 8;
   localparam int AddrW = 6;
   localparam int PcW = 11;
   localparam int ImmW = 10;
   localparam int PageBit = 2;
   localparam int NibbleLimit = 9;
   localparam logic [3:0] NibbleFix = 4'h6;
   localparam logic [DataW-1:0] DataOne = 8'h01;
   localparam logic [DataW-1:0] DataZero = 8'h00;
   localparam logic [PcW-1:0] PcReset = 11'h000;
   localparam logic [DataW-1:0] AccReset = 8'h00;

   // Operations that this block executes
   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_DECIMAL_ADJUST_AFTER_SUB = 3'h1,
      OP_DECREMENT_REG = 3'h2,
      OP_DECREMENT_SKIP_ZERO = 3'h3,
      OP_JUMP_ABSOLUTE = 3'h4,
      OP_INCREMENT_REG = 3'h5
   } op_t;

   // Execution phases: normal cycle, then a flush cycle for branches and skips
   typedef enum logic [0:0] {
      ST_RUN = 1'b0,
      ST_FLUSH = 1'b1
   } state_t;

   // One decoded instruction from the fetch stage
   typedef struct packed {
      logic valid;
      op_t op;
      logic [AddrW-1:0] regAddr;
      logic destReg;
      logic [ImmW-1:0] imm;
   } instr_t;

   // Write request toward the register file
   typedef struct packed {
      logic en;
      logic [AddrW-1:0] addr;
      logic [DataW-1:0] data;
   } reg_wr_t;

   // Status flag update request
   typedef struct packed {
      logic zeroEn;
      logic zero;
   } flag_upd_t;
endpackage

// >>> hdl/decimal_adjust_sub.sv
// Packed decimal correction of a byte after a subtraction
`timescale 1ns/10ps
module decimal_adjust_sub
   import exec_pkg::*;
(
   // Operand and borrows from the preceding subtraction
   input wire logic [exec_pkg::DataW-1:0] valueIn,
   input wire logic lowBorrow,
   input wire logic highBorrow,
   // Adjusted result
   output logic [exec_pkg::DataW-1:0] valueOut
);
   logic [3:0] lowNib;
   logic [3:0] highNib;

   always_comb
   begin
      lowNib = valueIn[3:0];
      highNib = valueIn[7:4];
      if (lowBorrow || (lowNib > 4'(NibbleLimit)))
      begin
         lowNib = lowNib - NibbleFix;
      end
      if (highBorrow || (highNib > 4'(NibbleLimit)))
      begin
         highNib = highNib - NibbleFix; // Wraps, as the borrow intends
      end
      valueOut = {highNib, lowNib};
   end
endmodule

// >>> test/tb_dec_inc_jump_execute.sv
// Self-checking bench for the decimal adjust, decrement, skip, jump and increment stage
`timescale 1ns/10ps
module tb_dec_inc_jump_execute;
   import exec_pkg::*;
   logic clock;
   logic sys_rst;
   instr_t instr;
   logic [DataW-1:0] regData;
   logic [DataW-1:0] pageHighBuffer;
   logic lowBorrow;
   logic highBorrow;
   reg_wr_t regWrite;
   flag_upd_t flagUpdate;
   logic [DataW-1:0] accumulator;
   logic [PcW-1:0] programCounter;
   logic pcLoad;
   logic flushCycle;
   int nMismatch;
   int nChecks;

   dec_inc_jump_execute #(.DATA_W(8)) dut (.clock(clock), .sys_rst(sys_rst), .instr(instr),
      .regData(regData), .pageHighBuffer(pageHighBuffer), .lowBorrow(lowBorrow),
      .highBorrow(highBorrow), .regWrite(regWrite), .flagUpdate(flagUpdate),
      .accumulator(accumulator), .programCounter(programCounter), .pcLoad(pcLoad),
      .flushCycle(flushCycle));

   // Free-running 40 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // Compare and count; four-state compare so unknowns never match
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      nChecks++;
      if (got !== exp)
      begin
         nMismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Pulse group: write enable, zero update, pc load, flush
   task automatic chkPulse(input logic [3:0] exp);
      chk({12'h000, regWrite.en, flagUpdate.zeroEn, pcLoad, flushCycle}, {12'h000, exp});
   endtask

   // Present one instruction just after an edge; it stays up until the next run or idle
   task automatic run(input op_t op, input logic [5:0] addr, input logic dest,
                      input logic [9:0] imm, input logic [7:0] rd);
      instr = '{1'b1, op, addr, dest, imm};
      regData = rd;
      @(posedge clock);
      #1;
   endtask

   // One empty cycle with a scrambled operand to catch late use, nothing may pulse
   task automatic idle;
      instr.valid = 1'b0;
      regData = ~regData;
      @(posedge clock);
      #1;
      chkPulse(4'h0);
   endtask

   task automatic t_inc;
      run(OP_INCREMENT_REG, 6'h05, 1'b0, 10'h000, 8'hff);
      chk({flagUpdate.zero, accumulator}, 9'h100);
      chkPulse(4'h4);
      run(OP_INCREMENT_REG, 6'h3f, 1'b1, 10'h000, 8'h41);
      chk({regWrite.addr, regWrite.data}, {6'h3f, 8'h42});
      chk({flagUpdate.zero, accumulator}, 9'h000);
      chkPulse(4'hc);
   endtask

   task automatic t_dec;
      run(OP_DECREMENT_REG, 6'h00, 1'b1, 10'h000, 8'h01);
      chk({regWrite.addr, regWrite.data, flagUpdate.zero}, 15'h0001);
      chkPulse(4'hc);
      run(OP_DECREMENT_REG, 6'h21, 1'b0, 10'h000, 8'h00);
      chk({flagUpdate.zero, accumulator}, 9'h0ff);
      chkPulse(4'h4);
   endtask

   task automatic t_skip;
      run(OP_DECREMENT_SKIP_ZERO, 6'h10, 1'b1, 10'h000, 8'h01);
      chk({regWrite.addr, regWrite.data}, {6'h10, 8'h00});
      chkPulse(4'h9);
      // Instruction offered during the flush must be dropped
      run(OP_INCREMENT_REG, 6'h01, 1'b0, 10'h000, 8'h7f);
      chk(accumulator, 8'hff);
      chkPulse(4'h0);
      run(OP_DECREMENT_SKIP_ZERO, 6'h02, 1'b0, 10'h000, 8'h05);
      chk(accumulator, 8'h04);
      chkPulse(4'h0);
      run(OP_DECREMENT_SKIP_ZERO, 6'h02, 1'b0, 10'h000, 8'h01);
      chk(accumulator, 8'h00);
      chkPulse(4'h1);
      idle();
   endtask

   task automatic t_jump;
      pageHighBuffer = 8'h04;
      run(OP_JUMP_ABSOLUTE, 6'h00, 1'b0, 10'h3ff, 8'h00);
      chk(programCounter, 11'h7ff);
      chkPulse(4'h3);
      idle();
      pageHighBuffer = 8'hfb;
      run(OP_JUMP_ABSOLUTE, 6'h00, 1'b0, 10'h155, 8'h00);
      chk(programCounter, 11'h155);
      chk(accumulator, 8'h00);
      chkPulse(4'h3);
      idle();
      // A skip that does not fire lets a jump right behind it run normally
      run(OP_DECREMENT_SKIP_ZERO, 6'h03, 1'b0, 10'h000, 8'h09);
      chk(accumulator, 8'h08);
      chkPulse(4'h0);
      run(OP_JUMP_ABSOLUTE, 6'h00, 1'b0, 10'h0aa, 8'h00);
      chk(programCounter, 11'h0aa);
      chk(accumulator, 8'h08);
      chkPulse(4'h3);
      idle();
   endtask

   // Load the accumulator through an increment, then adjust it
   task automatic decimal_adjust_after_sub(input logic [7:0] a, input logic lb, input logic hb,
                      input logic [7:0] exp);
      run(OP_INCREMENT_REG, 6'h00, 1'b0, 10'h000, a - 8'h01);
      lowBorrow = lb;
      highBorrow = hb;
      run(OP_DECIMAL_ADJUST_AFTER_SUB, 6'h00, 1'b0, 10'h000, 8'h00);
      lowBorrow = 1'b0;
      highBorrow = 1'b0;
      chk(accumulator, exp);
      chkPulse(4'h0);
   endtask

   // Verdict and end of run
   task automatic close_out;
      if (nMismatch == 0 && nChecks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      nMismatch = 0;
      nChecks = 0;
      sys_rst = 1'b1;
      instr = '0;
      regData = 8'h00;
      pageHighBuffer = 8'h00;
      lowBorrow = 1'b0;
      highBorrow = 1'b0;
      repeat (20) @(posedge clock);
      #1;
      sys_rst = 1'b0;
      chk(accumulator, 8'h00);
      chk(programCounter, 11'h000);
      chkPulse(4'h0);
      t_inc();
      t_dec();
      t_skip();
      t_jump();
      decimal_adjust_after_sub(8'h1e, 1'b1, 1'b0, 8'h18);
      decimal_adjust_after_sub(8'ha5, 1'b0, 1'b1, 8'h45);
      decimal_adjust_after_sub(8'hcc, 1'b0, 1'b0, 8'h66);
      decimal_adjust_after_sub(8'h42, 1'b0, 1'b0, 8'h42);
      close_out();
   end

   // Hang guard
   initial
   begin
      repeat (2000) @(posedge clock);
      nMismatch++;
      close_out();
   end
endmodule
